// ===== hw/ccep_map.vh
// Purpose: constants of the channel enable and protection block
// Assumes: 20 MHz clk_i, wishbone offsets are byte addresses
// Notes: none
`ifndef CCEP_MAP_VH
`define CCEP_MAP_VH
`define CCEP_ADR_CTRL 8'h00
`define CCEP_ADR_STAT 8'h04
`define CCEP_ADR_IRQ_STAT 8'h08
`define CCEP_ADR_IRQ_MASK 8'h0C
`define CCEP_ADR_FAULT 8'h10
`define CCEP_CTRL_RST 32'h0000_0000
`define CCEP_MASK_RST 32'h0000_0000
// ctrl bits
`define CCEP_CTRL_CLR_LATCH 0
// irq bits
`define CCEP_IRQ_MAIN_LATCH 0
`define CCEP_IRQ_RAIL_LATCH 1
`define CCEP_IRQ_UVLO 2
`define CCEP_IRQ_BL_OC 3
`define CCEP_IRQ_SEQ_DONE 4
`define CCEP_IRQ_W 5
// overcurrent persistence: 64 switching cycles at 1.5 MHz
`define CCEP_OC_CYC 64
`define CCEP_SW_KHZ 1500
`define CCEP_CLK_KHZ 20000
`define CCEP_OC_CNT ((`CCEP_OC_CYC * `CCEP_CLK_KHZ + `CCEP_SW_KHZ - 1) / `CCEP_SW_KHZ)
// default power sequence step delay, in microseconds
`define CCEP_STEP_US 100
`define CCEP_STEP_CNT (`CCEP_STEP_US * `CCEP_CLK_KHZ / 1000)
`endif

// ===== hw/ccep_seq.v
// Purpose: ordered on/off sequencer for one channel group
// Assumes: one clock, synchronous active-high reset
// Notes: step i enables output bit order position i; off runs in reverse
`timescale 1ns/1ps
module ccep_seq #(
  parameter N = 5,
  parameter STEP_CNT = 2000
) (
  input wire clk_i,
  input wire rst_i,
  input wire req_on_i,
  input wire kill_i,
  output wire [N-1:0] on_o,
  output wire busy_o
);
  reg [N:0] lvl_ff;
  reg [N:0] nxt_lvl;
  reg [31:0] tmr_ff;
  reg [31:0] nxt_tmr;
  wire [N:0] tgt;
  assign tgt = req_on_i ? N[N:0] : {(N+1){1'b0}};
  assign busy_o = (lvl_ff != tgt);
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_out
      assign on_o[g] = (lvl_ff > g);
    end
  endgenerate
  always @* begin
    nxt_lvl = lvl_ff;
    nxt_tmr = tmr_ff;
    if (kill_i) begin
      nxt_lvl = {(N+1){1'b0}};
      nxt_tmr = 32'h0000_0000;
    end else if (lvl_ff == tgt) begin
      nxt_tmr = 32'h0000_0000;
    end else if (tmr_ff + 32'h0000_0001 >= STEP_CNT) begin
      nxt_tmr = 32'h0000_0000;
      if (lvl_ff < tgt) begin
        nxt_lvl = lvl_ff + 1'b1;
      end else begin
        nxt_lvl = lvl_ff - 1'b1;
      end
    end else begin
      nxt_tmr = tmr_ff + 32'h0000_0001;
    end
  end
  always @(posedge clk_i) begin
    if (rst_i) begin
      lvl_ff <= {(N+1){1'b0}};
      tmr_ff <= 32'h0000_0000;
    end else begin
      lvl_ff <= nxt_lvl;
      tmr_ff <= nxt_tmr;
    end
  end
endmodule

// ===== hw/ccep_top.v
// Purpose: channel enable decode, sequencing and protection latch-off
// Assumes: 20 MHz clk_i, pins and analog comparators are asynchronous
// Notes: channel outputs are index 0..7 for channels 1..8, ref separate
//
// Design decisions made here: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "ccep_map.vh"
module ccep_top #(
  parameter STEP_CNT = `CCEP_STEP_CNT,
  parameter OC_CNT = `CCEP_OC_CNT
) (
  input wire clk_i,
  input wire rst_i,
  input wire sleep_release_n_i,
  input wire front_end_enable_i,
  input wire sensor_pair_enable_i,
  input wire backlight_enable_i,
  input wire sensor_sequence_select_i,
  input wire uvlo_i,
  input wire [5:0] oc_main_i,
  input wire [5:0] low_out_i,
  input wire bl_oc_i,
  input wire aux_low_i,
  input wire ref_low_i,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire irq_o,
  output reg [7:0] ch_on_o,
  output reg ref_on_o,
  output reg aux_pfm_o,
  output reg bl_switch_off_o,
  output reg [5:0] secondary_slope_o
);
  localparam NS = 13;
  // three-stage synchronisers for all asynchronous inputs
  wire [NS-1:0] raw;
  reg [NS-1:0] s1_ff;
  reg [NS-1:0] s2_ff;
  reg [NS-1:0] s3_ff;
  reg [NS-1:0] in_ff;
  // overcurrent only counts while that output is also low
  assign raw = {
    ref_low_i,
    aux_low_i,
    bl_oc_i,
    uvlo_i,
    sensor_sequence_select_i,
    backlight_enable_i,
    sensor_pair_enable_i,
    front_end_enable_i,
    sleep_release_n_i,
    |(oc_main_i[2:0] & low_out_i[2:0]),
    oc_main_i[4] & low_out_i[4],
    oc_main_i[5] & low_out_i[5],
    oc_main_i[3] & low_out_i[3]
  };
  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff <= {NS{1'b0}};
      s2_ff <= {NS{1'b0}};
      s3_ff <= {NS{1'b0}};
      in_ff <= {NS{1'b0}};
    end else begin
      s1_ff <= raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      in_ff <= (s2_ff & s3_ff) | (in_ff & (s2_ff | s3_ff));
    end
  end
  wire oc6 = in_ff[1];
  wire oc5 = in_ff[2];
  wire oc4 = in_ff[0];
  wire oc13 = in_ff[3];
  wire slp = in_ff[4];
  wire fe = in_ff[5];
  wire pe = in_ff[6];
  wire be = in_ff[7];
  wire sel56 = in_ff[8];
  wire uv = in_ff[9];
  wire bloc = in_ff[10];
  wire auxl = in_ff[11];
  wire refl = in_ff[12];
  reg slp_d_ff;
  reg fe_d_ff;
  reg pe_d_ff;
  reg uv_d_ff;
  always @(posedge clk_i) begin
    if (rst_i) begin
      slp_d_ff <= 1'b0;
      fe_d_ff <= 1'b0;
      pe_d_ff <= 1'b0;
      uv_d_ff <= 1'b1;
    end else begin
      slp_d_ff <= slp;
      fe_d_ff <= fe;
      pe_d_ff <= pe;
      uv_d_ff <= uv;
    end
  end
  wire slp_rise = slp & ~slp_d_ff;
  wire fe_rise = fe & ~fe_d_ff;
  wire pe_rise = pe & ~pe_d_ff;
  wire supply_back = uv_d_ff & ~uv;
  // software clear of latches, write-one pulse
  reg sw_clr_ff;
  // overcurrent persistence counters: ch1-3, ch4, ch5, ch6
  wire [3:0] oc_in = {oc6, oc5, oc4, oc13};
  wire [3:0] oc_hit;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_oc
      reg [15:0] cnt_ff;
      assign oc_hit[g] = (cnt_ff >= OC_CNT[15:0]);
      always @(posedge clk_i) begin
        if (rst_i || !oc_in[g]) begin
          cnt_ff <= 16'h0000;
        end else if (!oc_hit[g]) begin
          cnt_ff <= cnt_ff + 16'h0001;
        end
      end
    end
  endgenerate
  // latch-off per clear domain: ch1-3, ch4, ch5/6
  reg [2:0] oc_latch_ff;
  reg rail_latch_ff;
  wire com_clr = slp_rise | supply_back | sw_clr_ff;
  wire [2:0] oc_clr = {com_clr | pe_rise, com_clr | fe_rise, com_clr};
  wire [2:0] oc_set = {oc_hit[3] | oc_hit[2], oc_hit[1], oc_hit[0]};
  wire main_latch = |oc_latch_ff;
  wire main_set = |oc_hit;
  wire rail_clr = slp_rise | fe_rise | supply_back | sw_clr_ff;
  wire rail_set = auxl | refl;
  always @(posedge clk_i) begin
    if (rst_i) begin
      oc_latch_ff <= 3'h0;
      rail_latch_ff <= 1'b0;
    end else begin
      // set wins over clear
      oc_latch_ff <= oc_set | (oc_latch_ff & ~oc_clr);
      if (rail_set) begin
        rail_latch_ff <= 1'b1;
      end else if (rail_clr) begin
        rail_latch_ff <= 1'b0;
      end
    end
  end
  wire uv_stop = uv;
  wire kill = uv_stop | main_latch | rail_latch_ff;
  // request levels from the enable pins
  wire req_main = slp;
  wire req_ch4 = slp & fe;
  wire req_pair = slp & pe;
  wire req_ch7 = slp & be;
  wire [4:0] main_on;
  wire [1:0] pair_on;
  wire ch4_on;
  wire ch7_on;
  wire main_busy;
  wire pair_busy;
  wire ch4_busy;
  wire ch7_busy;
  // main group order: ref, ch8, ch1, ch2, ch3
  ccep_seq #(
    .N(5),
    .STEP_CNT(STEP_CNT)
  ) u_main (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_on_i(req_main),
    .kill_i(kill),
    .on_o(main_on),
    .busy_o(main_busy)
  );
  ccep_seq #(
    .N(2),
    .STEP_CNT(STEP_CNT)
  ) u_pair (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_on_i(req_pair),
    .kill_i(kill),
    .on_o(pair_on),
    .busy_o(pair_busy)
  );
  ccep_seq #(
    .N(1),
    .STEP_CNT(STEP_CNT)
  ) u_ch4 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_on_i(req_ch4),
    .kill_i(kill),
    .on_o(ch4_on),
    .busy_o(ch4_busy)
  );
  ccep_seq #(
    .N(1),
    .STEP_CNT(STEP_CNT)
  ) u_ch7 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_on_i(req_ch7),
    .kill_i(kill),
    .on_o(ch7_on),
    .busy_o(ch7_busy)
  );
  // aux-only low power state: sleep low with front-end enable high
  wire aux_only = ~slp & fe & ~kill;
  wire any_busy = main_busy | pair_busy | ch4_busy | ch7_busy;
  reg busy_d_ff;
  always @(posedge clk_i) begin
    if (rst_i) begin
      ch_on_o <= 8'h00;
      ref_on_o <= 1'b0;
      aux_pfm_o <= 1'b0;
      bl_switch_off_o <= 1'b0;
      secondary_slope_o <= 6'h00;
      busy_d_ff <= 1'b0;
    end else begin
      ch_on_o[0] <= main_on[2];
      ch_on_o[1] <= main_on[3];
      ch_on_o[2] <= main_on[4];
      ch_on_o[3] <= ch4_on;
      ch_on_o[4] <= pair_on[0];
      ch_on_o[5] <= pair_on[1];
      ch_on_o[6] <= ch7_on;
      ch_on_o[7] <= main_on[1] | aux_only;
      ref_on_o <= main_on[0];
      aux_pfm_o <= aux_only & ~main_on[1];
      bl_switch_off_o <= bloc;
      secondary_slope_o <= {1'b1, sel56, 4'h0};
      busy_d_ff <= any_busy;
    end
  end
  wire seq_done = busy_d_ff & ~any_busy;
  // interrupt status, write one to clear, set wins
  reg [`CCEP_IRQ_W-1:0] irq_stat_ff;
  reg [`CCEP_IRQ_W-1:0] irq_mask_ff;
  wire [`CCEP_IRQ_W-1:0] ev = {seq_done, bloc, uv, rail_set, main_set};
  assign irq_o = |(irq_stat_ff & irq_mask_ff);
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = wb_req & wb_we_i & wb_sel_i[0];
  wire [31:0] mask_rst = `CCEP_MASK_RST;
  // register offset match, upper address bits must be zero
  function adr_hit;
    input [31:0] a;
    input [7:0] off;
    begin
      adr_hit = (a[31:8] == 24'h00_0000) && (a[7:0] == off);
    end
  endfunction
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      irq_stat_ff <= {`CCEP_IRQ_W{1'b0}};
      irq_mask_ff <= mask_rst[`CCEP_IRQ_W-1:0];
      sw_clr_ff <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      sw_clr_ff <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      if (wr && adr_hit(wb_adr_i, `CCEP_ADR_IRQ_STAT)) begin
        irq_stat_ff <= (irq_stat_ff & ~wb_dat_i[`CCEP_IRQ_W-1:0]) | ev;
      end else begin
        irq_stat_ff <= irq_stat_ff | ev;
      end
      if (wr && adr_hit(wb_adr_i, `CCEP_ADR_IRQ_MASK)) begin
        irq_mask_ff <= wb_dat_i[`CCEP_IRQ_W-1:0];
      end
      if (wr && adr_hit(wb_adr_i, `CCEP_ADR_CTRL)) begin
        sw_clr_ff <= wb_dat_i[`CCEP_CTRL_CLR_LATCH];
      end
      if (wb_req && !wb_we_i) begin
        if (adr_hit(wb_adr_i, `CCEP_ADR_STAT)) begin
          wb_dat_o <= {18'h0_0000, aux_pfm_o, ref_on_o, ch_on_o, slp, fe, pe, be};
        end else if (adr_hit(wb_adr_i, `CCEP_ADR_IRQ_STAT)) begin
          wb_dat_o <= {27'h000_0000, irq_stat_ff};
        end else if (adr_hit(wb_adr_i, `CCEP_ADR_IRQ_MASK)) begin
          wb_dat_o <= {27'h000_0000, irq_mask_ff};
        end else if (adr_hit(wb_adr_i, `CCEP_ADR_FAULT)) begin
          wb_dat_o <= {27'h000_0000, any_busy, uv, bl_switch_off_o, rail_latch_ff, main_latch};
        end
      end
    end
  end
endmodule

// ===== dv/ccep_checker.sv
// Purpose: temporal checks on channel, slope and fault outputs
// Assumes: bound into ccep_top, inputs reach logic after the synchroniser
// Notes: repetition counts leave room for synchroniser and output latency
`timescale 1ns/1ps
module ccep_checker #(
  parameter STEP_CNT = 4,
  parameter OC_CNT = 4
) (
  input wire clk_i,
  input wire rst_i,
  input wire sensor_sequence_select_i,
  input wire uvlo_i,
  input wire [5:0] oc_main_i,
  input wire [5:0] low_out_i,
  input wire bl_oc_i,
  input wire aux_low_i,
  input wire ref_low_i,
  input wire [7:0] ch_on_o,
  input wire ref_on_o,
  input wire bl_switch_off_o,
  input wire [5:0] secondary_slope_o
);
  reg [15:0] oc_ff;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // consecutive cycles of overcurrent with a low output
  always @(posedge clk_i) begin
    if (rst_i || !(|(oc_main_i & low_out_i)))
      oc_ff <= 16'h0000;
    else if (oc_ff != 16'hffff)
      oc_ff <= oc_ff + 16'h0001;
  end
  property p_uvlo; uvlo_i [*8] |-> ch_on_o == 8'h00 && !ref_on_o; endproperty
  a_uvlo: assert property (p_uvlo) else $error("uvlo left a rail on");
  property p_oc; oc_ff == OC_CNT + 10 |-> ch_on_o == 8'h00; endproperty
  a_oc: assert property (p_oc) else $error("overcurrent not latched");
  property p_aux; aux_low_i [*8] |-> ch_on_o == 8'h00 && !ref_on_o; endproperty
  a_aux: assert property (p_aux) else $error("aux fault not latched");
  property p_ref; ref_low_i [*8] |-> ch_on_o == 8'h00 && !ref_on_o; endproperty
  a_ref: assert property (p_ref) else $error("ref fault not latched");
  property p_bl; $stable(bl_oc_i) [*8] |-> bl_switch_off_o == bl_oc_i; endproperty
  a_bl: assert property (p_bl) else $error("backlight switch wrong");
  property p_slope; $stable(sensor_sequence_select_i) [*8] |->
    secondary_slope_o == {1'b1, sensor_sequence_select_i, 4'h0}; endproperty
  a_slope: assert property (p_slope) else $error("slope select wrong");
  property p_main; ch_on_o[0] |-> ref_on_o && ch_on_o[7] && (ch_on_o[2] <= ch_on_o[1]) && (ch_on_o[1] <= ch_on_o[0]);
  endproperty
  a_main: assert property (p_main) else $error("main group order broken");
  property p_pair; ch_on_o[5] |-> ch_on_o[4]; endproperty
  a_pair: assert property (p_pair) else $error("pair order broken");
endmodule
bind ccep_top ccep_checker #(.STEP_CNT(STEP_CNT), .OC_CNT(OC_CNT)) u_chk (.*);

// ===== dv/ccep_host.sv
// Purpose: host that walks the enable pins between table states
// Assumes: state_i 1..10 names the wanted pin state
// Notes: front-end and pair enables wait for channels 1-3
`timescale 1ns/1ps
module ccep_host (
  input wire clk_i,
  input wire rst_i,
  input wire [3:0] state_i,
  input wire [7:0] ch_on_i,
  output reg sleep_release_n_o,
  output reg front_end_enable_o,
  output reg sensor_pair_enable_o,
  output reg backlight_enable_o
);
  wire [3:0] s = state_i - 4'h2;
  wire up = &ch_on_i[2:0];
  wire in2 = sleep_release_n_o & ~front_end_enable_o & ~sensor_pair_enable_o & ~backlight_enable_o;
  always @(posedge clk_i) begin
    if (rst_i || state_i < 4'h2) begin
      {sleep_release_n_o, front_end_enable_o, sensor_pair_enable_o, backlight_enable_o} <= 4'h0;
    end else if (state_i == 4'ha) begin
      if (in2 & up | ~sleep_release_n_o & front_end_enable_o)
        {sleep_release_n_o, front_end_enable_o} <= 2'b01;
      else
        {sleep_release_n_o, front_end_enable_o, sensor_pair_enable_o, backlight_enable_o} <= 4'h8;
    end else begin
      sleep_release_n_o <= 1'b1;
      backlight_enable_o <= s[0];
      sensor_pair_enable_o <= s[1] & up;
      front_end_enable_o <= s[2] & up;
    end
  end
endmodule

// ===== dv/tb.sv
// Purpose: directed bench for channel enable and protection
// Assumes: sequencer step and overcurrent count shortened to 4
// Notes: pin states come from the host model
`timescale 1ns/1ps
`include "ccep_map.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module tb;
  reg clk_i = 0, rst_i = 1, sensor_sequence_select_i = 0, uvlo_i = 0, bl_oc_i = 0, aux_low_i = 0, ref_low_i = 0;
  reg [5:0] oc_main_i = 0, low_out_i = 0;
  reg [31:0] wb_adr_i = 0, wb_dat_i = 0, q;
  reg [3:0] wb_sel_i = 0, state_i = 1;
  reg wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, seen;
  wire sleep_release_n_i, front_end_enable_i, sensor_pair_enable_i, backlight_enable_i;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, irq_o, ref_on_o, aux_pfm_o, bl_switch_off_o;
  wire [7:0] ch_on_o;
  wire [5:0] secondary_slope_o;
  integer fails = 0, check_count = 0, cyc = 0, i;
  always #25 clk_i = ~clk_i;
  ccep_top #(.STEP_CNT(4), .OC_CNT(4)) DUT (.*);
  ccep_host u_host (.clk_i(clk_i), .rst_i(rst_i), .state_i(state_i), .ch_on_i(ch_on_o),
    .sleep_release_n_o(sleep_release_n_i), .front_end_enable_o(front_end_enable_i),
    .sensor_pair_enable_o(sensor_pair_enable_i), .backlight_enable_o(backlight_enable_i));
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      end_sim;
    end
  end
  task wt(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  task go(input [3:0] s);
    begin
      state_i <= s;
      wt(80);
    end
  endtask
  task wb(input [7:0] a, input w, input [31:0] d);
    begin
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, w, 4'hf};
      wb_adr_i <= {24'h00_0000, a};
      wb_dat_i <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
    end
  endtask
  initial begin
    wt(12);
    rst_i <= 0;
    wt(1);
    `CHK({ref_on_o, ch_on_o}, 9'h000)
    wb(`CCEP_ADR_IRQ_MASK, 0, 0);
    `CHK(q, `CCEP_MASK_RST)
    wb(8'h20, 0, 0);
    `CHK(q, 32'h0000_0000)
    for (i = 0; i < 8; i++) begin
      go(i[3:0] + 4'h2);
      `CHK({ref_on_o, aux_pfm_o, ch_on_o}, {2'b10, 1'b1, i[0], i[1], i[1], i[2], 3'h7})
    end
    for (i = 0; i < 2; i++) begin
      sensor_sequence_select_i <= i[0];
      bl_oc_i <= !i[0];
      wt(12);
      `CHK({bl_switch_off_o, secondary_slope_o}, {!i[0], 1'b1, i[0], 4'h0})
    end
    go(10);
    `CHK({ref_on_o, aux_pfm_o, ch_on_o}, 10'h180)
    go(2);
    state_i <= 1;
    seen = 0;
    repeat (60) begin
      @(posedge clk_i);
      seen = seen | (!ch_on_o[2] && ref_on_o);
    end
    `CHK({seen, ch_on_o}, 9'h100)
    go(9);
    uvlo_i <= 1;
    wt(20);
    `CHK(ch_on_o, 8'h00)
    uvlo_i <= 0;
    wt(80);
    `CHK(ch_on_o[2:0], 3'h7)
    go(9);
    for (i = 0; i < 3; i++) begin
      {aux_low_i, ref_low_i, oc_main_i[2], low_out_i[2]} <= {i == 0, i == 1, i == 2, i == 2};
      wt(20);
      {aux_low_i, ref_low_i, oc_main_i[2], low_out_i[2]} <= 4'h0;
      wt(60);
      `CHK({ref_on_o, ch_on_o}, 9'h000)
      go(1);
      go(9);
      `CHK({ref_on_o, ch_on_o}, 9'h1ff)
    end
    wb(`CCEP_ADR_STAT, 0, 0);
    `CHK(q, 32'h0000_1fff)
    wb(`CCEP_ADR_IRQ_STAT, 1, 32'h0000_001f);
    wb(`CCEP_ADR_IRQ_MASK, 1, 32'h0000_0002);
    ref_low_i <= 1;
    wt(20);
    ref_low_i <= 0;
    `CHK(irq_o, 1'b1)
    wb(`CCEP_ADR_IRQ_MASK, 1, 32'h0000_0000);
    `CHK(irq_o, 1'b0)
    wb(`CCEP_ADR_IRQ_STAT, 0, 0);
    `CHK(q[1], 1'b1)
    wb(`CCEP_ADR_IRQ_STAT, 1, 32'h0000_0002);
    wb(`CCEP_ADR_IRQ_STAT, 0, 0);
    `CHK(q[1], 1'b0)
    go(1);
    wb(`CCEP_ADR_FAULT, 0, 0);
    `CHK(q, 32'h0000_0002)
    wb(`CCEP_ADR_CTRL, 1, 32'h0000_0001);
    wb(`CCEP_ADR_FAULT, 0, 0);
    `CHK(q, 32'h0000_0000)
    end_sim;
  end
endmodule
